//--- rtl/acw_map.svh
`ifndef ACW_MAP_SVH
`define ACW_MAP_SVH

// Control word field positions
`define ACW_WORD_W        24
`define ACW_MODE_HI       23
`define ACW_MODE_LO       21
`define ACW_GAIN_HI       20
`define ACW_GAIN_LO       18
`define ACW_PICK_BIT      17
`define ACW_SLEEP_BIT     16
`define ACW_SIZE_BIT      15
`define ACW_EXCITE_BIT    14
`define ACW_BURN_BIT      13
`define ACW_POL_BIT       12
`define ACW_NOTCH_HI      11
`define ACW_NOTCH_LO      0

// Reset value of the control word
`define ACW_WORD_RESET    24'h000000

// Synchroniser reset at idle pin levels: clock low, frames high, select and data low
`define ACW_SYNC_RESET    5'h0c

// Frame lengths in serial clocks
`define ACW_FULL_BITS     5'h18
`define ACW_SHORT_BITS    5'h10

// Calibration step time and its cycle count at 50 MHz
`define ACW_CLK_MHZ       50
`define ACW_CAL_STEP_US   200
`define ACW_CAL_STEP_CYC  (`ACW_CAL_STEP_US * `ACW_CLK_MHZ)

`endif

//--- rtl/acw_pkg.sv
`include "acw_map.svh"
`default_nettype none

package acw_pkg;

	typedef enum logic [2:0] {
		ACW_MODE_NORMAL   = 3'h0,
		ACW_MODE_SELF_CAL = 3'h1,
		ACW_MODE_SYS_ZERO = 3'h2,
		ACW_MODE_SYS_FULL = 3'h3
	} acw_mode_t;

	typedef enum logic [4:0] {
		ACW_ST_IDLE      = 5'h01,
		ACW_ST_SELF_ZERO = 5'h02,
		ACW_ST_SELF_FULL = 5'h04,
		ACW_ST_SYS_ZERO  = 5'h08,
		ACW_ST_SYS_FULL  = 5'h10
	} acw_state_t;

	typedef logic [`ACW_WORD_W-1:0] acw_word_t;

endpackage

`default_nettype wire

//--- rtl/acw_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface acw_link_if;
	import acw_pkg::*;

	logic      wr_done;
	acw_word_t wr_word;
	logic      wr_sel;
	logic      frame_sel;
	acw_word_t rd_word;
	logic      rd_len24;
	logic      rd_allow;
	logic      rd_done;
	logic      rd_sel;

	modport port (
		output wr_done,
		output wr_word,
		output wr_sel,
		output frame_sel,
		input  rd_word,
		input  rd_len24,
		input  rd_allow,
		output rd_done,
		output rd_sel
	);

	modport core (
		input  wr_done,
		input  wr_word,
		input  wr_sel,
		input  frame_sel,
		output rd_word,
		output rd_len24,
		output rd_allow,
		input  rd_done,
		input  rd_sel
	);

endinterface

`default_nettype wire

//--- rtl/acw_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "acw_map.svh"

module acw_serial_port
	import acw_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	input  wire logic   serial_clk_i,
	input  wire logic   transmit_frame_n_i,
	input  wire logic   receive_frame_n_i,
	input  wire logic   register_select_i,
	input  wire logic   serial_io_i,
	output logic        serial_io_o,
	output logic        serial_io_oe_o,
	acw_link_if.port    lnk
);

	// Two-stage synchronisers, then a third stage for edge finding
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] s3_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= `ACW_SYNC_RESET;
			s2_q <= `ACW_SYNC_RESET;
			s3_q <= `ACW_SYNC_RESET;
		end else begin
			s1_q <= {serial_clk_i, transmit_frame_n_i, receive_frame_n_i,
				register_select_i, serial_io_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic tfs_fall;
	logic tfs_rise;
	logic rfs_fall;
	logic tfs_low;
	logic rfs_low;
	assign sclk_rise = s2_q[4] & ~s3_q[4];
	assign sclk_fall = ~s2_q[4] & s3_q[4];
	assign tfs_fall  = ~s2_q[3] & s3_q[3];
	assign tfs_rise  = s2_q[3] & ~s3_q[3];
	assign rfs_fall  = ~s2_q[2] & s3_q[2];
	assign tfs_low   = ~s2_q[3];
	assign rfs_low   = ~s2_q[2];
	assign lnk.frame_sel = s2_q[1];

	// Write path
	acw_word_t win_q;
	logic [4:0] wcnt_q;
	logic       wsel_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_q  <= `ACW_WORD_RESET;
			wcnt_q <= 5'h00;
			wsel_q <= 1'b0;
		end else if (tfs_fall) begin
			wcnt_q <= 5'h00;
			wsel_q <= s2_q[1];
		end else if (tfs_low && sclk_rise && wcnt_q < `ACW_FULL_BITS) begin
			win_q  <= {win_q[`ACW_WORD_W-2:0], s2_q[0]};
			wcnt_q <= wcnt_q + 5'h01; // Clocks past 24 fall through
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lnk.wr_done <= 1'b0;
			lnk.wr_word <= `ACW_WORD_RESET;
			lnk.wr_sel  <= 1'b0;
		end else begin
			// Short frames never reach the core
			lnk.wr_done <= tfs_rise && (wcnt_q == `ACW_FULL_BITS);
			lnk.wr_word <= win_q;
			lnk.wr_sel  <= wsel_q;
		end
	end

	// Read path: bit changes on falling serial clock, host samples on rising
	acw_word_t rout_q;
	logic [4:0] rcnt_q;
	logic       ract_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rout_q         <= `ACW_WORD_RESET;
			rcnt_q         <= 5'h00;
			ract_q         <= 1'b0;
			lnk.rd_sel     <= 1'b0;
			lnk.rd_done    <= 1'b0;
			serial_io_o    <= 1'b0;
			serial_io_oe_o <= 1'b0;
		end else begin
			lnk.rd_done <= 1'b0;
			if (!rfs_low) begin
				ract_q         <= 1'b0;
				serial_io_oe_o <= 1'b0;
			end else if (rfs_fall && lnk.rd_allow) begin
				rout_q         <= lnk.rd_word;
				rcnt_q         <= lnk.rd_len24 ? `ACW_FULL_BITS : `ACW_SHORT_BITS;
				ract_q         <= 1'b1;
				lnk.rd_sel     <= s2_q[1];
				serial_io_o    <= lnk.rd_word[`ACW_WORD_W-1];
				serial_io_oe_o <= 1'b1;
			end else if (ract_q && sclk_fall) begin
				rout_q      <= {rout_q[`ACW_WORD_W-2:0], 1'b0};
				serial_io_o <= rout_q[`ACW_WORD_W-2];
				rcnt_q      <= rcnt_q - 5'h01;
				if (rcnt_q == 5'h01) begin
					ract_q         <= 1'b0;
					serial_io_oe_o <= 1'b0;
					lnk.rd_done    <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- rtl/acw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "acw_map.svh"

// Overview of operation
// - A complete write frame with register select low goes into the control word.
// - A read frame with register select low shifts out the current control word.
// - Of the write frames, only a full 24-bit one updates the control word; shorter frames change nothing.
// - Serial clocks after the 24th within one write frame are ignored.
// - The word goes MSB first: mode, gain, input pick, sleep, size, excitation, burnout, polarity, notch.
// - Mode 000 is normal mode and the reset default; a select-high read returns conversion data.
// - Mode 001 runs a self-calibration of the picked input, then clears the mode to 000.
// - Self-calibration takes zero scale from shorted inputs and full scale from the reference.
// - Data ready goes low when the self-calibration has finished.
// - Mode 010 runs a zero-scale system calibration, flags data ready, then returns to normal.
// - Data ready falls when a new output word is ready and rises once a full word has been sent.
// - Mode 011 runs a full-scale system calibration, flags data ready, then returns to normal.
module acw_ctrl
	import acw_pkg::*;
#(
	parameter int unsigned CAL_STEP_CYCLES = `ACW_CAL_STEP_CYC
)(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        serial_clk_i,
	input  wire logic        transmit_frame_n_i,
	input  wire logic        receive_frame_n_i,
	input  wire logic        register_select_i,
	input  wire logic        serial_io_i,
	output logic             serial_io_o,
	output logic             serial_io_oe_o,
	output logic             data_ready_n_o,
	input  wire logic [23:0] conv_data_i,
	input  wire logic        conv_valid_i,
	output logic [2:0]       gain_bits_o,
	output logic             input_pick_o,
	output logic             sleep_bit_o,
	output logic             word_size_bit_o,
	output logic             excitation_bit_o,
	output logic             burnout_bit_o,
	output logic             polarity_bit_o,
	output logic [11:0]      notch_code_o,
	output logic             cal_busy_o,
	output logic             cal_zero_step_o,
	output logic             cal_full_step_o,
	output logic             inputs_shorted_o,
	output logic             ref_applied_o
);

	acw_link_if lnk ();

	acw_serial_port u_port (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n_i),
		.serial_clk_i       (serial_clk_i),
		.transmit_frame_n_i (transmit_frame_n_i),
		.receive_frame_n_i  (receive_frame_n_i),
		.register_select_i  (register_select_i),
		.serial_io_i        (serial_io_i),
		.serial_io_o        (serial_io_o),
		.serial_io_oe_o     (serial_io_oe_o),
		.lnk                (lnk.port)
	);

	function automatic logic [2:0] mode_of(input acw_word_t w);
		mode_of = w[`ACW_MODE_HI:`ACW_MODE_LO];
	endfunction

	function automatic logic is_zero_step(input acw_state_t s);
		is_zero_step = (s == ACW_ST_SELF_ZERO) || (s == ACW_ST_SYS_ZERO);
	endfunction

	function automatic logic is_full_step(input acw_state_t s);
		is_full_step = (s == ACW_ST_SELF_FULL) || (s == ACW_ST_SYS_FULL);
	endfunction

	// Control word
	acw_word_t  ctrl_q;
	acw_state_t state_q;
	logic [31:0] cnt_q;
	logic        step_end;
	logic        cal_write;
	logic        cal_done;

	assign step_end  = (state_q != ACW_ST_IDLE) && (cnt_q == CAL_STEP_CYCLES - 1);
	assign cal_write = lnk.wr_done && !lnk.wr_sel;
	assign cal_done  = step_end && (state_q != ACW_ST_SELF_ZERO);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `ACW_WORD_RESET; // Power-on default is normal mode
		end else if (cal_write) begin
			ctrl_q <= lnk.wr_word; // Select low targets the control word
		end else if (cal_done) begin
			// Mode held during the calibration, cleared only at the end of its last step
			ctrl_q[`ACW_MODE_HI:`ACW_MODE_LO] <= ACW_MODE_NORMAL;
		end
	end

	// Step counter; wide so that long step times fit without rework
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 32'h0;
		end else if (cal_write) begin
			cnt_q <= 32'h0;
		end else if (state_q == ACW_ST_IDLE || step_end) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	// Calibration sequencer; a new write restarts from its own mode
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ACW_ST_IDLE;
		end else if (cal_write) begin
			case (mode_of(lnk.wr_word))
				ACW_MODE_SELF_CAL: state_q <= ACW_ST_SELF_ZERO;
				ACW_MODE_SYS_ZERO: state_q <= ACW_ST_SYS_ZERO;
				ACW_MODE_SYS_FULL: state_q <= ACW_ST_SYS_FULL;
				default:           state_q <= ACW_ST_IDLE;
			endcase
		end else begin
			case (state_q)
				ACW_ST_IDLE:      state_q <= ACW_ST_IDLE;
				ACW_ST_SELF_ZERO: state_q <= step_end ? ACW_ST_SELF_FULL : ACW_ST_SELF_ZERO;
				ACW_ST_SELF_FULL: state_q <= step_end ? ACW_ST_IDLE : ACW_ST_SELF_FULL;
				ACW_ST_SYS_ZERO:  state_q <= step_end ? ACW_ST_IDLE : ACW_ST_SYS_ZERO;
				ACW_ST_SYS_FULL:  state_q <= step_end ? ACW_ST_IDLE : ACW_ST_SYS_FULL;
				default:          state_q <= ACW_ST_IDLE;
			endcase
		end
	end

	// Analog steering for the current calibration step
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_busy_o       <= 1'b0;
			cal_zero_step_o  <= 1'b0;
			cal_full_step_o  <= 1'b0;
			inputs_shorted_o <= 1'b0;
			ref_applied_o    <= 1'b0;
		end else begin
			cal_busy_o       <= (state_q != ACW_ST_IDLE);
			cal_zero_step_o  <= is_zero_step(state_q);
			cal_full_step_o  <= is_full_step(state_q);
			inputs_shorted_o <= (state_q == ACW_ST_SELF_ZERO);
			ref_applied_o    <= (state_q == ACW_ST_SELF_FULL);
		end
	end

	// Field outputs, one cycle behind the word
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_bits_o      <= 3'h0;
			input_pick_o     <= 1'b0;
			sleep_bit_o      <= 1'b0;
			word_size_bit_o  <= 1'b0;
			excitation_bit_o <= 1'b0;
			burnout_bit_o    <= 1'b0;
			polarity_bit_o   <= 1'b0;
			notch_code_o     <= 12'h000;
		end else begin
			gain_bits_o      <= ctrl_q[`ACW_GAIN_HI:`ACW_GAIN_LO];
			input_pick_o     <= ctrl_q[`ACW_PICK_BIT];
			sleep_bit_o      <= ctrl_q[`ACW_SLEEP_BIT];
			word_size_bit_o  <= ctrl_q[`ACW_SIZE_BIT];
			excitation_bit_o <= ctrl_q[`ACW_EXCITE_BIT];
			burnout_bit_o    <= ctrl_q[`ACW_BURN_BIT];
			polarity_bit_o   <= ctrl_q[`ACW_POL_BIT];
			notch_code_o     <= ctrl_q[`ACW_NOTCH_HI:`ACW_NOTCH_LO]; // Range kept by host
		end
	end

	// Conversion data latch; conversions are dropped while calibrating or asleep
	acw_word_t data_q;
	logic      new_word;
	assign new_word = conv_valid_i && (state_q == ACW_ST_IDLE) && !ctrl_q[`ACW_SLEEP_BIT];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_q <= `ACW_WORD_RESET;
		end else if (new_word) begin
			data_q <= conv_data_i;
		end
	end

	// Data ready: set wins over the end-of-read clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_ready_n_o <= 1'b1;
		end else if (cal_done || new_word) begin
			data_ready_n_o <= 1'b0;
		end else if (cal_write && mode_of(lnk.wr_word) != ACW_MODE_NORMAL) begin
			data_ready_n_o <= 1'b1;
		end else if (lnk.rd_done && lnk.rd_sel) begin
			data_ready_n_o <= 1'b1; // Full output word sent
		end
	end

	// Read source; 16-bit data words leave left-aligned
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lnk.rd_word  <= `ACW_WORD_RESET;
			lnk.rd_len24 <= 1'b1;
			lnk.rd_allow <= 1'b0;
		end else if (!lnk.frame_sel) begin
			lnk.rd_word  <= ctrl_q; // Live word, mode included
			lnk.rd_len24 <= 1'b1;   // Host takes all 24 bits
			lnk.rd_allow <= 1'b1;
		end else begin
			// Coefficient modes are not served here and read as zero
			lnk.rd_word  <= (mode_of(ctrl_q) == ACW_MODE_NORMAL) ? data_q : `ACW_WORD_RESET;
			lnk.rd_len24 <= ctrl_q[`ACW_SIZE_BIT];
			lnk.rd_allow <= !data_ready_n_o;
		end
	end

endmodule

`default_nettype wire

//--- tb/acw_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acw_ctrl_chk #(
	parameter int unsigned CAL_STEP_CYCLES = 20
)(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        transmit_frame_n_i,
	input wire logic        receive_frame_n_i,
	input wire logic        conv_valid_i,
	input wire logic        serial_io_oe_o,
	input wire logic        data_ready_n_o,
	input wire logic [2:0]  gain_bits_o,
	input wire logic        sleep_bit_o,
	input wire logic [11:0] notch_code_o,
	input wire logic        cal_busy_o,
	input wire logic        cal_zero_step_o,
	input wire logic        cal_full_step_o,
	input wire logic        inputs_shorted_o,
	input wire logic        ref_applied_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Run length of the zero step; one cycle of slack for the state register
	int unsigned zrun_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			zrun_q <= 0;
		else if (cal_zero_step_o)
			zrun_q <= zrun_q + 1;
		else
			zrun_q <= 0;
	end
	a_step_length: assert property ($fell(cal_zero_step_o) |->
		zrun_q + 1 >= CAL_STEP_CYCLES && zrun_q <= CAL_STEP_CYCLES + 1) else $error("zero step length");
	a_short_ref_excl: assert property (!(inputs_shorted_o && ref_applied_o))
		else $error("shorted and reference together");
	a_short_is_zero: assert property (inputs_shorted_o |-> cal_zero_step_o)
		else $error("shorted outside zero step");
	a_ref_is_full: assert property (ref_applied_o |-> cal_full_step_o)
		else $error("reference outside full step");
	a_cal_done_flag: assert property ($fell(cal_busy_o) |-> ##[0:2] !data_ready_n_o)
		else $error("no ready after calibration");
	a_fields_hold: assert property ($changed({gain_bits_o, sleep_bit_o, notch_code_o})
		|-> transmit_frame_n_i) else $error("fields moved inside frame");
	a_conv_ready: assert property (conv_valid_i && !cal_busy_o && !sleep_bit_o
		|-> ##1 !data_ready_n_o) else $error("no ready after conversion");
	a_oe_after_frame: assert property ($rose(serial_io_oe_o) |-> $past(!receive_frame_n_i, 2))
		else $error("drive without read frame");
	a_oe_idle_off: assert property (receive_frame_n_i [*4] |-> !serial_io_oe_o)
		else $error("drive outside read frame");
endmodule
bind acw_ctrl acw_ctrl_chk #(.CAL_STEP_CYCLES(CAL_STEP_CYCLES)) acw_ctrl_chk_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .transmit_frame_n_i(transmit_frame_n_i),
	.receive_frame_n_i(receive_frame_n_i), .conv_valid_i(conv_valid_i),
	.serial_io_oe_o(serial_io_oe_o), .data_ready_n_o(data_ready_n_o),
	.gain_bits_o(gain_bits_o), .sleep_bit_o(sleep_bit_o), .notch_code_o(notch_code_o),
	.cal_busy_o(cal_busy_o), .cal_zero_step_o(cal_zero_step_o),
	.cal_full_step_o(cal_full_step_o), .inputs_shorted_o(inputs_shorted_o),
	.ref_applied_o(ref_applied_o));
`default_nettype wire

//--- tb/acw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acw_host_model (
	input  wire logic clk_i,
	input  wire logic sio_i,
	output logic      sclk_o,
	output logic      wfrm_n_o,
	output logic      rfrm_n_o,
	output logic      sel_o,
	output logic      drv_o,
	output logic      bit_o
);
	// Serial clock stands low outside frames; 8 clk period gives 160 ns
	initial begin
		sclk_o = 0;
		wfrm_n_o = 1;
		rfrm_n_o = 1;
		sel_o = 0;
		drv_o = 0;
		bit_o = 0;
	end
	task automatic half();
		repeat (4) @(negedge clk_i);
	endtask
	task automatic wr(input logic [23:0] w, input int n);
		sel_o = 0;
		half();
		wfrm_n_o = 0;
		drv_o = 1;
		for (int i = 0; i < n; i++) begin
			bit_o = (i < 24) ? w[23 - i] : ~bit_o;
			half();
			sclk_o = 1;
			half();
			sclk_o = 0;
		end
		half();
		wfrm_n_o = 1;
		half();
		drv_o = 0;
		repeat (3) half();
	endtask
	// Sampled just before the rising edge, after the device moved on the fall
	task automatic rd(input logic s, input int n, output logic [23:0] d);
		sel_o = s;
		half();
		rfrm_n_o = 0;
		d = 24'h000000;
		half();
		half();
		for (int i = 0; i < n; i++) begin
			d = {d[22:0], sio_i};
			sclk_o = 1;
			half();
			sclk_o = 0;
			half();
		end
		rfrm_n_o = 1;
		repeat (3) half();
	endtask
endmodule
`default_nettype wire

//--- tb/adc_control_word_and_cal_modes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_word_and_cal_modes_bench;
	localparam int unsigned CAL = 300;
	logic        clk_i = 0;
	logic        rst_n_i = 0;
	logic        conv_valid_i = 0;
	logic [23:0] conv_data_i = 24'h000000;
	logic        sclk, wfn, rfn, sel, drv, hb, sio_o, oe, data_ready_n_n;
	logic        pick, sleep, size, exc, burn, pol, line;
	logic [2:0]  gain;
	logic [11:0] notch;
	logic [23:0] d;
	int          err_total = 0;
	int          compares = 0;
	always #10 clk_i = ~clk_i;
	// Released line shows the inverse of its last driven level
	assign line = oe ? sio_o : (drv ? hb : ~hb);
	acw_host_model acw_host_model_inst (.clk_i(clk_i), .sio_i(line), .sclk_o(sclk),
		.wfrm_n_o(wfn), .rfrm_n_o(rfn), .sel_o(sel), .drv_o(drv), .bit_o(hb));
	acw_ctrl #(.CAL_STEP_CYCLES(CAL)) acw_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.serial_clk_i(sclk), .transmit_frame_n_i(wfn), .receive_frame_n_i(rfn),
		.register_select_i(sel), .serial_io_i(line), .serial_io_o(sio_o),
		.serial_io_oe_o(oe), .data_ready_n_o(data_ready_n_n), .conv_data_i(conv_data_i),
		.conv_valid_i(conv_valid_i), .gain_bits_o(gain), .input_pick_o(pick),
		.sleep_bit_o(sleep), .word_size_bit_o(size), .excitation_bit_o(exc),
		.burnout_bit_o(burn), .polarity_bit_o(pol), .notch_code_o(notch), .cal_busy_o(),
		.cal_zero_step_o(), .cal_full_step_o(), .inputs_shorted_o(), .ref_applied_o());
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [23:0] flds();
		return {3'h0, gain, pick, sleep, size, exc, burn, pol, notch};
	endfunction
	initial begin
		repeat (20) @(negedge clk_i);
		chk("fields", 24'h000000, flds());
		chk("ready_n", 24'h000001, {23'h0, data_ready_n_n});
		rst_n_i = 1;
		repeat (4) @(negedge clk_i);
		acw_host_model_inst.rd(0, 24, d);
		chk("word", 24'h000000, d);
		acw_host_model_inst.wr(24'h16d3e8, 24);
		chk("fields", 24'h16d3e8, flds());
		acw_host_model_inst.rd(0, 24, d);
		chk("word", 24'h16d3e8, d);
		$display("test basic done");
		acw_host_model_inst.wr(24'hfff000, 12);
		acw_host_model_inst.rd(0, 24, d);
		chk("word", 24'h16d3e8, d);
		acw_host_model_inst.wr(24'h0a4013, 30);
		acw_host_model_inst.rd(0, 24, d);
		chk("word", 24'h0a4013, d);
		$display("test framing done");
		for (int m = 1; m < 4; m++) begin
			acw_host_model_inst.wr({m[2:0], 21'h0a4013}, 24);
			acw_host_model_inst.rd(0, 24, d);
			chk("busy word", {m[2:0], 21'h0a4013}, d);
			for (int t = 0; t < 2000 && data_ready_n_n; t++)
				@(negedge clk_i);
			chk("cal ready_n", 24'h000000, {23'h0, data_ready_n_n});
			acw_host_model_inst.rd(0, 24, d);
			chk("done word", 24'h0a4013, d);
		end
		$display("test calibration done");
		acw_host_model_inst.rd(1, 16, d);
		chk("empty data", 24'h000000, d);
		chk("ready_n", 24'h000001, {23'h0, data_ready_n_n});
		@(negedge clk_i);
		conv_data_i = 24'hc3a55a;
		conv_valid_i = 1;
		@(negedge clk_i);
		conv_valid_i = 0;
		@(negedge clk_i);
		chk("ready_n", 24'h000000, {23'h0, data_ready_n_n});
		acw_host_model_inst.rd(1, 16, d);
		chk("data", 24'h00c3a5, d);
		chk("ready_n", 24'h000001, {23'h0, data_ready_n_n});
		$display("test data done");
		tally_and_finish();
	end
	// Tests need about 4300 cycles; over nine times that is a hang
	initial begin
		repeat (40000) @(posedge clk_i);
		err_total++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
